// ===== otpp_pkg.sv
// constants, timings and types for the otp program-port host controller
package otpp_pkg;
  localparam int ADDR_W       = 17;
  localparam int DATA_W       = 8;
  localparam int PAGE_BYTES   = 4;
  localparam int PAGE_W       = PAGE_BYTES * DATA_W;
  localparam int CNT_W        = 13;
  localparam int MAX_ATTEMPTS = 10;
  localparam int ATT_W        = 4;

  // clock and pin timings
  localparam int CLK_PERIOD_PS = 25000;
  localparam int PULSE_TIME_NS = 100000;
  localparam int SETUP_TIME_NS = 100;
  localparam int ACCESS_TIME_NS = 200;
  localparam int ENTER_TIME_NS = 2000;

  // cycle counts: exact pulse, least times rounded up
  localparam logic [CNT_W-1:0] PULSE_CYC  = CNT_W'((PULSE_TIME_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] SETUP_CYC  = CNT_W'((SETUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] ACCESS_CYC = CNT_W'((ACCESS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] ENTER_CYC  = CNT_W'((ENTER_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // address map of the device, attempt limit and attempt reset value
  localparam logic [ADDR_W-1:0] FIRST_ADDR = 17'h00000;
  localparam logic [ADDR_W-1:0] LAST_ADDR  = 17'h0EFFF;
  localparam logic [ATT_W-1:0]  ATT_MAX    = 4'hA;
  localparam logic [ATT_W-1:0]  ATT_RST    = 4'h0;

  typedef enum logic [1:0] {OP_READ, OP_BYTE, OP_PAGE} otpp_op_t;

  typedef enum logic [3:0] {
    S_IDLE, S_ENTER, S_LATCH_SET, S_LATCH_STB, S_PULSE, S_OUT_SET, S_OUT_READ, S_FINISH
  } otpp_state_t;
endpackage : otpp_pkg

// ===== otpp_timer_if.sv
// carrier between the sequencer and its wait timer
`timescale 1ns/10ps
interface otpp_timer_if;
  import otpp_pkg::*;
  logic             start;
  logic [CNT_W-1:0] len;
  logic             done;
  modport master (output start, output len, input done);
  modport timer  (input start, input len, output done);
endinterface : otpp_timer_if

// ===== otpp_timer.sv
// wait timer: done marks the len-th cycle after start
`timescale 1ns/10ps
module otpp_timer
  import otpp_pkg::*;
(
  // clock and reset
  input  wire logic   i_clk_sys,
  input  wire logic   i_rst_n,
  // control
  otpp_timer_if.timer tmr
);
  logic [CNT_W-1:0] cnt_reg;

  // load on start, then count down to zero
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      cnt_reg <= '0;
    else if (tmr.start)
      cnt_reg <= tmr.len;
    else if (cnt_reg != '0)
      cnt_reg <= cnt_reg - CNT_W'(1);
  end

  assign tmr.done = (cnt_reg == CNT_W'(1));
endmodule : otpp_timer

// ===== otpp_host.sv
// host controller that reads and programs the otp memory through its pins
// Contract
// - keep device reset low, supply level selected
// - supply fixed at read level during reads
// - address out; ce and oe low read data
// - page: ce, oe high, one 0.1 ms pulse
// - byte: ce low, oe high, 0.1 ms pulse
// - repeat pulse and verify, ten attempts at most
// - writes only within 0000H to EFFFH
`timescale 1ns/10ps
module otpp_host
  import otpp_pkg::*;
(
  // clock and reset
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rst_n,
  // command port
  input  wire logic                        i_cmd_valid,
  input  wire otpp_pkg::otpp_op_t          i_cmd_op,
  input  wire logic [otpp_pkg::ADDR_W-1:0] i_cmd_addr,
  input  wire logic [otpp_pkg::PAGE_W-1:0] i_cmd_wdata,
  output logic                             o_cmd_ready,
  output logic                             o_done,
  output logic [otpp_pkg::DATA_W-1:0]      o_rd_data,
  output logic                             o_fail,
  output logic                             o_range_err,
  output logic [otpp_pkg::ATT_W-1:0]       o_attempts,
  // device pins
  output logic                             o_dev_reset_n,
  output logic                             o_vpp_write,
  output logic                             o_ce_n,
  output logic                             o_oe_n,
  output logic                             o_program_pulse_n,
  output logic [otpp_pkg::ADDR_W-1:0]      o_prom_address_bus,
  output logic [otpp_pkg::DATA_W-1:0]      o_prom_data_bus,
  output logic                             o_prom_data_oe_n,
  input  wire logic [otpp_pkg::DATA_W-1:0] i_prom_data_bus
);
  import otpp_pkg::*;

  otpp_state_t       state_reg, state_next;
  otpp_op_t          op_reg;
  logic [ADDR_W-1:0] base_reg;
  logic [PAGE_W-1:0] wdata_reg;
  logic [1:0]        idx_reg;
  logic [ATT_W-1:0]  att_reg;
  logic              miss_reg;
  logic              mismatch;
  logic              last_byte;
  logic              out_of_range;
  logic [ADDR_W-1:0] end_addr;
  logic              vpp_next, ce_n_next, oe_n_next, pgm_n_next, drive_next;
  logic [DATA_W-1:0] exp_byte;

  otpp_timer_if tmr ();

  otpp_timer u_timer (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .tmr       (tmr)
  );

  // request checks and byte selection
  assign end_addr     = (i_cmd_op == OP_PAGE) ? {i_cmd_addr[ADDR_W-1:2], 2'b11} : i_cmd_addr;
  assign out_of_range = (i_cmd_op != OP_READ) && (end_addr > LAST_ADDR);
  assign exp_byte     = wdata_reg[{idx_reg, 3'b000} +: DATA_W];
  assign mismatch     = (i_prom_data_bus != exp_byte);
  assign last_byte    = (op_reg != OP_PAGE) || (idx_reg == 2'(PAGE_BYTES - 1));
  assign o_cmd_ready  = (state_reg == S_IDLE);

  // sequencer next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:
        if (i_cmd_valid)
          state_next = out_of_range ? S_FINISH : S_ENTER;
      S_ENTER:
        if (tmr.done)
          state_next = (op_reg == OP_READ) ? S_OUT_SET : S_LATCH_SET;
      S_LATCH_SET:
        if (tmr.done)
          state_next = (op_reg == OP_PAGE) ? S_LATCH_STB : S_PULSE;
      S_LATCH_STB:
        if (tmr.done)
          state_next = last_byte ? S_PULSE : S_LATCH_SET;
      S_PULSE:
        if (tmr.done)
          state_next = S_OUT_SET;
      S_OUT_SET:
        if (tmr.done)
          state_next = S_OUT_READ;
      S_OUT_READ:
        if (tmr.done)
        begin
          if (op_reg == OP_READ)
            state_next = S_FINISH;
          else if (!last_byte)
            state_next = S_OUT_SET;
          else if ((miss_reg || mismatch) && (att_reg < ATT_MAX))
            state_next = (op_reg == OP_PAGE) ? S_PULSE : S_LATCH_SET;
          else
            state_next = S_FINISH;
        end
      S_FINISH:
        state_next = S_IDLE;
      default:
        state_next = S_IDLE;
    endcase
  end

  // wait length for the state being entered
  always_comb
  begin
    tmr.start = (state_next != state_reg) && (state_next != S_IDLE) && (state_next != S_FINISH);
    case (state_next)
      S_ENTER:    tmr.len = ENTER_CYC;
      S_PULSE:    tmr.len = PULSE_CYC;
      S_OUT_READ: tmr.len = ACCESS_CYC;
      default:    tmr.len = SETUP_CYC;
    endcase
  end

  // state register
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      state_reg <= S_IDLE;
    else
      state_reg <= state_next;
  end

  // command capture, page base aligned to four bytes
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      op_reg    <= OP_READ;
      base_reg  <= FIRST_ADDR;
      wdata_reg <= '0;
    end
    else if ((state_reg == S_IDLE) && i_cmd_valid)
    begin
      op_reg    <= i_cmd_op;
      base_reg  <= (i_cmd_op == OP_PAGE) ? {i_cmd_addr[ADDR_W-1:2], 2'b00} : i_cmd_addr;
      wdata_reg <= i_cmd_wdata;
    end
  end

  // byte index within the page
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      idx_reg <= 2'h0;
    else if ((state_reg == S_IDLE) || (state_next == S_PULSE))
      idx_reg <= 2'h0;
    else if (tmr.done && !last_byte && ((state_reg == S_LATCH_STB) || (state_reg == S_OUT_READ)))
      idx_reg <= idx_reg + 2'h1;
  end

  // attempt count and verify miss tracking
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      att_reg  <= ATT_RST;
      miss_reg <= 1'b0;
    end
    else if (state_reg == S_IDLE)
    begin
      att_reg  <= ATT_RST;
      miss_reg <= 1'b0;
    end
    else
    begin
      if ((state_next == S_PULSE) && (state_reg != S_PULSE))
      begin
        att_reg  <= att_reg + ATT_W'(1);
        miss_reg <= 1'b0;
      end
      else if ((state_reg == S_OUT_READ) && tmr.done && (op_reg != OP_READ) && mismatch)
        miss_reg <= 1'b1;
    end
  end

  // results toward the user
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_done      <= 1'b0;
      o_rd_data   <= '0;
      o_fail      <= 1'b0;
      o_range_err <= 1'b0;
      o_attempts  <= ATT_RST;
    end
    else
    begin
      o_done <= (state_next == S_FINISH);
      if ((state_reg == S_IDLE) && i_cmd_valid)
      begin
        o_fail      <= 1'b0;
        o_range_err <= out_of_range;
      end
      if ((state_reg == S_OUT_READ) && tmr.done)
      begin
        o_rd_data <= i_prom_data_bus;
        if ((op_reg != OP_READ) && last_byte && (miss_reg || mismatch) && (att_reg >= ATT_MAX))
          o_fail <= 1'b1;
      end
      if (state_next == S_FINISH)
        o_attempts <= att_reg;
    end
  end

  // pin levels for each state
  always_comb
  begin
    vpp_next   = (state_next != S_IDLE) && (state_next != S_FINISH) && (op_reg != OP_READ);
    ce_n_next  = 1'b1;
    oe_n_next  = 1'b1;
    pgm_n_next = 1'b1;
    drive_next = 1'b0;
    case (state_next)
      S_LATCH_SET:
      begin
        ce_n_next  = (op_reg == OP_PAGE);
        drive_next = 1'b1;
      end
      S_LATCH_STB:
      begin
        oe_n_next  = 1'b0;
        drive_next = 1'b1;
      end
      S_PULSE:
      begin
        ce_n_next  = (op_reg == OP_PAGE);
        pgm_n_next = 1'b0;
        drive_next = (op_reg != OP_PAGE);
      end
      S_OUT_SET:
        ce_n_next = 1'b0;
      S_OUT_READ:
      begin
        ce_n_next = 1'b0;
        oe_n_next = 1'b0;
      end
      default:
        ce_n_next = 1'b1;
    endcase
  end

  // registered pins, bus released whenever the device may drive
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_dev_reset_n      <= 1'b0;
      o_vpp_write        <= 1'b0;
      o_ce_n             <= 1'b1;
      o_oe_n             <= 1'b1;
      o_program_pulse_n  <= 1'b1;
      o_prom_address_bus <= FIRST_ADDR;
      o_prom_data_bus    <= '0;
      o_prom_data_oe_n   <= 1'b1;
    end
    else
    begin
      o_dev_reset_n      <= 1'b0;
      o_vpp_write        <= vpp_next;
      o_ce_n             <= ce_n_next;
      o_oe_n             <= oe_n_next;
      o_program_pulse_n  <= pgm_n_next;
      o_prom_address_bus <= (op_reg == OP_PAGE) ? {base_reg[ADDR_W-1:2], idx_reg} : base_reg;
      o_prom_data_bus    <= exp_byte;
      o_prom_data_oe_n   <= !drive_next;
    end
  end

  // helper: length of the current program pulse
  logic [CNT_W-1:0] pulse_len_reg;
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n || o_program_pulse_n)
      pulse_len_reg <= '0;
    else
      pulse_len_reg <= pulse_len_reg + CNT_W'(1);
  end

  // helper: page latch strobes ended so far in this command
  logic       oe_n_d_reg;
  logic [1:0] latched_reg;
  always_ff @(posedge i_clk_sys)
  begin
    oe_n_d_reg  <= !i_rst_n || o_oe_n;
    latched_reg <= (!i_rst_n || o_cmd_ready) ? 2'h0 : latched_reg + 2'(o_ce_n && o_oe_n && !oe_n_d_reg);
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence s_pulse_end;
    $rose(o_program_pulse_n);
  endsequence

  sequence s_verify_read;
    !o_ce_n && !o_oe_n && o_program_pulse_n && o_prom_data_oe_n;
  endsequence

  a_reset_kept_low: assert property (!o_dev_reset_n)
    else $error("device reset released");
  a_read_supply_fixed: assert property ((op_reg == OP_READ) && !o_ce_n |-> !o_vpp_write && $stable(o_vpp_write))
    else $error("supply not at read level during read");
  a_read_bus_free: assert property (!o_ce_n && !o_oe_n |-> o_prom_data_oe_n)
    else $error("host drives data bus during read");
  a_pulse_width: assert property (s_pulse_end |-> pulse_len_reg == PULSE_CYC)
    else $error("program pulse width wrong");
  a_page_pulse_pins: assert property (!o_program_pulse_n && (op_reg == OP_PAGE) |-> o_ce_n && o_oe_n)
    else $error("page pulse with wrong strobes");
  a_byte_pulse_pins: assert property (!o_program_pulse_n && (op_reg == OP_BYTE)
                                      |-> !o_ce_n && o_oe_n && !o_prom_data_oe_n)
    else $error("byte pulse with wrong strobes");
  a_verify_follows: assert property (s_pulse_end |-> ##[1:20] s_verify_read)
    else $error("no verify read after pulse");
  a_attempt_limit: assert property ($fell(o_program_pulse_n) |-> att_reg <= ATT_MAX)
    else $error("too many program attempts");
  a_write_range: assert property (!o_program_pulse_n |-> o_prom_address_bus <= LAST_ADDR)
    else $error("write outside program range");
  a_page_aligned: assert property (o_ce_n && !o_oe_n |-> o_prom_address_bus[1:0] == latched_reg
                                   && o_prom_address_bus[ADDR_W-1:2] == base_reg[ADDR_W-1:2])
    else $error("page byte address misplaced");
endmodule : otpp_host

// ===== otpp_dev_model.sv
// behavioural model of the otp device in programming mode
`timescale 1ns/10ps
module otpp_dev_model
  import otpp_pkg::*;
(
  // device pins
  input  wire logic                        i_reset_n,
  input  wire logic                        i_vpp_write,
  input  wire logic                        i_ce_n,
  input  wire logic                        i_oe_n,
  input  wire logic                        i_program_pulse_n,
  input  wire logic [otpp_pkg::ADDR_W-1:0] i_prom_address_bus,
  input  wire logic [otpp_pkg::DATA_W-1:0] i_prom_data_bus,
  // fault injection
  input  wire logic                        i_stuck_en,
  input  wire logic [otpp_pkg::ADDR_W-1:0] i_stuck_addr,
  // data bus drive and pulse check
  output logic                             o_drive,
  output logic [otpp_pkg::DATA_W-1:0]      o_data,
  output int                               o_bad_pulse
);
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] page_q [PAGE_BYTES];
  logic [ADDR_W-1:0] page_base;
  time               fall_t;
  logic              armed = 1'b0;
  initial o_bad_pulse = 0;
  // a stuck cell ignores writes
  task automatic poke(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    if (!(i_stuck_en && a == i_stuck_addr))
      mem[a] = d;
  endtask : poke
  // drives only in read or verify, floats otherwise
  assign o_drive = !i_reset_n && !i_ce_n && !i_oe_n && i_program_pulse_n;
  // stored byte, erased cells read all ones
  always @(i_ce_n, i_oe_n, i_program_pulse_n, i_prom_address_bus)
    o_data = mem.exists(i_prom_address_bus) ? mem[i_prom_address_bus] : 8'hFF;
  // page latch, one slot per low address bits
  always @(negedge i_oe_n)
    if (i_ce_n && i_program_pulse_n && i_vpp_write)
    begin
      page_q[i_prom_address_bus[1:0]] = i_prom_data_bus;
      page_base = {i_prom_address_bus[ADDR_W-1:2], 2'h0};
    end
  // writes happen only on a falling pulse pin
  always @(negedge i_program_pulse_n)
  begin
    fall_t = $time;
    armed = 1'b1;
    #1; // strobes changed on the same clock edge settle before the mode is decoded
    if (i_vpp_write && i_ce_n && i_oe_n)
      for (int k = 0; k < PAGE_BYTES; k++)
        poke(page_base + ADDR_W'(k), page_q[k]);
    else if (i_vpp_write && !i_ce_n && i_oe_n)
      poke(i_prom_address_bus, i_prom_data_bus);
  end
  // counts pulses of the wrong width
  always @(posedge i_program_pulse_n)
    if (armed && ($time - fall_t) != PULSE_TIME_NS)
      o_bad_pulse = o_bad_pulse + 1;
endmodule : otpp_dev_model

// ===== otp_prom_program_port_bench.sv
// self-checking bench of the otp host controller against the device model
`timescale 1ns/10ps
module otp_prom_program_port_bench;
  import otpp_pkg::*;
  typedef struct packed {logic [7:0] rd; logic chk_rd; logic fail; logic rng; logic [3:0] att;} otpp_note_t;
  logic              clk_sys, rst_n, cmd_valid, cmd_ready, done, fail, range_err, dev_reset_n, vpp_write;
  logic              ce_n, oe_n, pgm_n, data_oe_n, dev_drive, stuck_en;
  otpp_op_t          cmd_op, cur_op;
  logic [ADDR_W-1:0] cmd_addr, addr_bus, base;
  logic [PAGE_W-1:0] cmd_wdata, d;
  logic [DATA_W-1:0] rd_data, data_out, dev_data, last_bus;
  logic [ATT_W-1:0]  attempts;
  wire  [DATA_W-1:0] bus_w;
  int                bad_pulse, error_cnt, compares;
  otpp_note_t        exp_q[$];
  otpp_note_t        nt;
  // clock
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // wire level: host, device, else the inverse of the last driven level
  assign bus_w = !data_oe_n ? data_out : dev_drive ? dev_data : ~last_bus;
  always @(posedge clk_sys)
    if (!data_oe_n || dev_drive)
      last_bus <= bus_w;
  otpp_host dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op),
    .i_cmd_addr(cmd_addr), .i_cmd_wdata(cmd_wdata), .o_cmd_ready(cmd_ready), .o_done(done),
    .o_rd_data(rd_data), .o_fail(fail), .o_range_err(range_err), .o_attempts(attempts),
    .o_dev_reset_n(dev_reset_n), .o_vpp_write(vpp_write), .o_ce_n(ce_n), .o_oe_n(oe_n),
    .o_program_pulse_n(pgm_n), .o_prom_address_bus(addr_bus), .o_prom_data_bus(data_out),
    .o_prom_data_oe_n(data_oe_n), .i_prom_data_bus(bus_w));
  otpp_dev_model dev (.i_reset_n(dev_reset_n), .i_vpp_write(vpp_write), .i_ce_n(ce_n), .i_oe_n(oe_n),
    .i_program_pulse_n(pgm_n), .i_prom_address_bus(addr_bus), .i_prom_data_bus(bus_w),
    .i_stuck_en(stuck_en), .i_stuck_addr(17'h00100), .o_drive(dev_drive), .o_data(dev_data),
    .o_bad_pulse(bad_pulse));
  // one comparison
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // verdict and end of run
  task automatic end_sim;
    if (error_cnt == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  // issue one command, note its result, wait until it is checked
  task automatic send(input otpp_op_t op, input logic [16:0] a, input logic [31:0] w, input otpp_note_t n);
    int k;
    @(posedge clk_sys);
    exp_q.push_back(n);
    cur_op = op;
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= w;
    @(posedge clk_sys);
    chk("cmd_ready", 1, cmd_ready);
    cmd_valid <= 1'b0;
    for (k = 0; k < 60000 && exp_q.size() != 0; k++)
      @(posedge clk_sys);
    if (exp_q.size() != 0)
    begin
      chk("done_timeout", 0, 1);
      exp_q.delete();
    end
  endtask : send
  // result checks on done, pin checks every cycle
  always @(posedge clk_sys)
  begin
    if (done === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("unexpected_done", 0, 1);
      else
      begin
        nt = exp_q.pop_front();
        if (nt.chk_rd)
          chk("rd_data", nt.rd, rd_data);
        chk("fail", nt.fail, fail);
        chk("range_err", nt.rng, range_err);
        chk("attempts", nt.att, attempts);
      end
    end
    if (rst_n)
    begin
      chk("dev_reset_n", 0, dev_reset_n);
      chk("contention", 0, !data_oe_n && dev_drive);
      if (!pgm_n)
        chk("vpp_in_pulse", 1, vpp_write);
      if (cur_op == OP_READ && !ce_n)
        chk("vpp_in_read", 0, vpp_write);
    end
  end
  // watchdog
  initial
  begin
    repeat (95000) @(posedge clk_sys);
    error_cnt++;
    end_sim;
  end
  // main sequence
  initial
  begin
    {cmd_valid, stuck_en, cmd_addr, cmd_wdata} = '0;
    cmd_op = OP_READ;
    cur_op = OP_READ;
    rst_n = 1'b0;
    last_bus = 8'h00;
    error_cnt = 0;
    compares = 0;
    void'($urandom(17110));
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    // blank reads, one above the write range
    send(OP_READ, 17'($urandom_range(17'h0EFFF, 0)), 0, '{8'hFF, 1, 0, 0, 0});
    send(OP_READ, 17'h1F000, 0, '{8'hFF, 1, 0, 0, 0});
    // byte writes, random and at the last address, read back
    for (int p = 0; p < 2; p++)
    begin
      base = p ? LAST_ADDR : 17'($urandom_range(17'h0EFFF, 17'h00200));
      d = $urandom;
      send(OP_BYTE, base, d, '{d[7:0], 1, 0, 0, 1});
      send(OP_READ, base, 0, '{d[7:0], 1, 0, 0, 0});
    end
    // page writes, random and the top page, read back byte by byte
    for (int p = 0; p < 2; p++)
    begin
      base = p ? 17'h0EFFC : 17'($urandom_range(32'h3BFE, 32'h80)) << 2;
      d = $urandom;
      send(OP_PAGE, base | 17'h3, d, '{d[31:24], 1, 0, 0, 1});
      for (int k = 0; k < 4; k++)
        send(OP_READ, base + 17'(k), 0, '{d[8*k+:8], 1, 0, 0, 0});
    end
    // writes past the range are refused
    send(OP_BYTE, 17'h0F000, 32'h12, '{8'h00, 0, 0, 1, 0});
    send(OP_PAGE, 17'h0F000, 32'h12, '{8'h00, 0, 0, 1, 0});
    // a stuck cell gives up after ten pulses
    stuck_en <= 1'b1;
    send(OP_BYTE, 17'h00100, 32'h5A, '{8'hFF, 1, 1, 0, ATT_MAX});
    stuck_en <= 1'b0;
    send(OP_READ, 17'h00100, 0, '{8'hFF, 1, 0, 0, 0});
    chk("bad_pulse", 0, bad_pulse);
    end_sim;
  end
endmodule : otp_prom_program_port_bench
